/* File: core/tspc_pkg.sv */
package tspc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_FUNC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0c;
   // reset values
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [15:0] FUNC_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0004;
   // preproc_config fields
   localparam int CFG_SEL_HI = 15;
   localparam int CFG_SEL_LO = 14;
   localparam int CFG_FILT_MSB = 13;
   localparam int CFG_FILT_LSB = 10;
   localparam int CFG_TZONE_LSB = 8;
   localparam int CFG_AZONE_LSB = 6;
   localparam logic [15:0] CONFIG_WMASK = 16'hffdf;
   localparam int CFG_CHAN_FILTER_EN_X = 4;
   localparam int CFG_CHAN_FILTER_EN_Y = 3;
   localparam int CFG_CHAN_FILTER_EN_Z = 2;
   localparam int CFG_CHAN_FILTER_EN_AUX = 1;
   localparam int CFG_CHAN_FILTER_EN_TEMP = 0;
   // control fields
   localparam int CTL_CODE_LSB = 0;
   localparam int CTL_SELF_SCAN = 4;
   localparam int CTL_STOP = 5;
   localparam int CTL_SOFT_RST = 6;
   localparam int CTL_START = 7;
   // function status fields
   localparam int FUNC_COUNT = 13;
   localparam int FUNC_DRV_X = 13;
   localparam int FUNC_DRV_Y = 14;
   localparam int FUNC_DRV_YX = 15;
   // status fields
   localparam int STS_DAV_LSB = 9;
   localparam int STS_RST_FLAG = 7;
   localparam int STS_XOK = 6;
   localparam int STS_YOK = 5;
   localparam int STS_YNS = 3;
   localparam int STS_PDN = 2;
   // channels: 0 x, 1 y, 2 z1, 3 z2, 4 aux, 5 temp1, 6 temp2
   localparam int CHAN_COUNT = 7;
   localparam logic [2:0] CHAN_AUX = 3'h4;
   localparam logic [2:0] CHAN_TEMP1 = 3'h5;
   localparam logic [2:0] CHAN_TEMP2 = 3'h6;
   // zone codes
   localparam logic [1:0] ZONE_OFF = 2'h0;
   localparam logic [1:0] ZONE_BELOW = 2'h1;
   localparam logic [1:0] ZONE_INSIDE = 2'h2;
   // processed result from the filter arithmetic
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [11:0] value;
   } tspc_result_t;
   // panel driver states
   typedef struct packed {
      logic xPos;
      logic xNeg;
      logic yPos;
      logic yNeg;
   } tspc_drivers_t;
   // zone thresholds
   typedef struct packed {
      logic [11:0] auxHigh;
      logic [11:0] auxLow;
      logic [11:0] tempHigh;
      logic [11:0] tempLow;
   } tspc_thresh_t;
endpackage : tspc_pkg

/* File: core/tspc_regs.sv */
// Notes on behaviour
// - select 00: pin is pen irq (low active) ANDed with inverted data-available.
// - low select bit one: pin shows data-available, active low.
// - select 10: pin shows pen touch irq only.
// - filter control defaults zero; zero bypasses the preprocessor.
// - while filter processes, busy and affected data-available flags show busy.
// - filter control bits read back as written.
// - zone enabled: store and flag only results meeting the criterion.
// - zone code 00 stores and flags without comparison.
// - zone 01 below low, 10 between, 11 above high threshold.
// - separate zone codes for temperature and auxiliary channels.
// - filter applied per channel enable before any zone comparison.
// - five channel filter enables reset zero; one applies the filter.
// - bits 15..13 show active panel driver pairs, else zero.
// - driver bits clear on completion, stop or any reset.
// - low thirteen bits one-hot on the running function code.
// - function bits clear on completion, stop or any reset.
// - self scan keeps bit 0 or 1 when scan ends for no touch.
// - status bits 15..9 mirror the seven data-available flags.
// - flag set on store, held until host read all updated registers.
// - status register resets to 0004h; here bits 1:0 hold VERSION_ID, default 2, so it reads 0006h after reset.
// - preproc_config resets to zero, select bits included.
// - function status register resets to zero.
// - reset flag reads zero after a reset until a status poll.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tspc_regs #(
   parameter logic [1:0] VERSION_ID = 2'h2 // arbitrary value
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic penTouchIrq_n,
   output logic combinedIrqPin,
   input wire tspc_pkg::tspc_result_t procResult,
   input wire tspc_pkg::tspc_thresh_t thresholds,
   input wire tspc_pkg::tspc_drivers_t drivers,
   input wire logic [6:0] filterBusy,
   input wire logic [6:0] allRegsRead,
   input wire logic funcDone,
   input wire logic scanNoTouch,
   input wire logic xPanelOk,
   input wire logic yPanelOk,
   input wire logic yNoShort,
   input wire logic powerdownIn,
   output logic [6:0] chanFilterOn,
   output logic [3:0] filterSetting,
   output logic [6:0] storeStrobe,
   output logic [11:0] storeValue,
   output logic funcStart,
   output logic [3:0] funcCode,
   output logic selfScanSel,
   output logic stopReq,
   output logic convBusy,
   output logic softResetOut
);
   import tspc_pkg::*;

   // zone test on a processed result
   function automatic logic zoneOk(input logic [1:0] zone, input logic [11:0] v,
                                   input logic [11:0] lo, input logic [11:0] hi);
      logic ok;
      ok = 1'b1;
      unique case (zone)
         ZONE_OFF: ok = 1'b1;
         ZONE_BELOW: ok = (v < lo);
         ZONE_INSIDE: ok = (v >= lo) && (v <= hi);
         default: ok = (v > hi);
      endcase
      return ok;
   endfunction : zoneOk

   // channel number to its filter enable bit; z1/z2 and the temperatures share one
   function automatic int maveBit(input int chan);
      int b;
      b = CFG_CHAN_FILTER_EN_TEMP;
      unique case (chan)
         0: b = CFG_CHAN_FILTER_EN_X;
         1: b = CFG_CHAN_FILTER_EN_Y;
         2, 3: b = CFG_CHAN_FILTER_EN_Z;
         4: b = CFG_CHAN_FILTER_EN_AUX;
         default: b = CFG_CHAN_FILTER_EN_TEMP;
      endcase
      return b;
   endfunction : maveBit

   logic [15:0] config_reg;
   logic [7:0] control_reg;
   logic [12:0] funcOneHot_reg;
   logic [2:0] driverBits_reg;
   logic [6:0] dav_reg;
   logic resetFlag_reg;
   logic powerdown_state_reg;
   logic softRst_reg;
   logic penSync1_reg;
   logic penSync2_reg;
   logic pin_reg;
   logic [31:0] rdata_reg;
   logic [6:0] store_reg;
   logic [11:0] value_reg;
   logic start_reg;
   logic stop_reg;
   logic anyRst;
   logic setup;
   logic access;
   logic wrAccess;
   logic rdStatus;
   logic mapped;
   logic wrCtl;
   logic running;
   logic accept;
   logic [6:0] davShown;
   logic davAny;
   logic [15:0] funcWord;
   logic [15:0] statusWord;
   logic [3:0] wrCode;

   // software reset acts like the system reset on everything but itself and the two pen irq flops
   assign anyRst = sys_rst | softRst_reg;

   // bus phases and decode
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wrAccess = access & pwrite & mapped;
   assign mapped = (paddr == ADDR_CONFIG) || (paddr == ADDR_FUNC) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_CONTROL);
   assign rdStatus = access & ~pwrite & (paddr == ADDR_STATUS);
   assign wrCtl = wrAccess & (paddr == ADDR_CONTROL);
   assign wrCode = pwdata[CTL_CODE_LSB +: 4];
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = rdata_reg;

   // pen irq pin passes two flops
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         penSync1_reg <= 1'b1;
         penSync2_reg <= 1'b1;
      end else begin
         penSync1_reg <= penTouchIrq_n;
         penSync2_reg <= penSync1_reg;
      end
   end

   // software reset bit stays until software writes zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         softRst_reg <= 1'b0;
      end else if (wrCtl) begin
         softRst_reg <= pwdata[CTL_SOFT_RST];
      end
   end

   // preprocessor configuration
   always_ff @(posedge clock) begin
      if (anyRst) begin
         config_reg <= CONFIG_RESET;
      end else if (wrAccess && paddr == ADDR_CONFIG) begin
         config_reg <= pwdata[15:0] & CONFIG_WMASK;
      end
   end

   // control: code and self scan select; start and stop read back as zero
   always_ff @(posedge clock) begin
      if (anyRst) begin
         control_reg <= 8'h00;
      end else if (wrCtl) begin
         control_reg <= {1'b0, pwdata[CTL_SOFT_RST], 1'b0, pwdata[4:0]};
      end
   end

   // one-shot start and stop; a code past the last function never starts
   always_ff @(posedge clock) begin
      if (anyRst) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         start_reg <= wrCtl & pwdata[CTL_START] & (wrCode < 4'(FUNC_COUNT));
         stop_reg <= wrCtl & pwdata[CTL_STOP];
      end
   end

   // one-hot running function indicator
   always_ff @(posedge clock) begin
      if (anyRst) begin
         funcOneHot_reg <= FUNC_RESET[12:0];
      end else if (stop_reg) begin
         funcOneHot_reg <= 13'h0000;
      end else if (start_reg) begin
         funcOneHot_reg <= 13'(13'h0001 << control_reg[3:0]);
      end else if (funcDone) begin
         if (scanNoTouch && control_reg[CTL_SELF_SCAN] &&
             (funcOneHot_reg[0] || funcOneHot_reg[1])) begin
            funcOneHot_reg <= funcOneHot_reg;
         end else begin
            funcOneHot_reg <= 13'h0000;
         end
      end
   end

   assign running = |funcOneHot_reg;

   // panel driver pairs, only while a function runs
   always_ff @(posedge clock) begin
      if (anyRst || stop_reg || funcDone || !running) begin
         driverBits_reg <= 3'h0;
      end else begin
         driverBits_reg[0] <= drivers.xPos & drivers.xNeg;
         driverBits_reg[1] <= drivers.yPos & drivers.yNeg;
         driverBits_reg[2] <= drivers.yPos & drivers.xNeg;
      end
   end

   // filter routing per channel; an all-zero setting bypasses every channel
   assign filterSetting = config_reg[CFG_FILT_MSB:CFG_FILT_LSB];
   generate
      for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_filt
         assign chanFilterOn[c] = (|filterSetting) &
                                  config_reg[maveBit(c)];
      end
   endgenerate

   // zone detection on the already filtered result
   always_comb begin
      if (procResult.chan == CHAN_AUX) begin
         accept = zoneOk(config_reg[CFG_AZONE_LSB +: 2], procResult.value,
                         thresholds.auxLow, thresholds.auxHigh);
      end else if (procResult.chan == CHAN_TEMP1 || procResult.chan == CHAN_TEMP2) begin
         accept = zoneOk(config_reg[CFG_TZONE_LSB +: 2], procResult.value,
                         thresholds.tempLow, thresholds.tempHigh);
      end else begin
         accept = 1'b1;
      end
   end

   // store strobes toward the data registers
   always_ff @(posedge clock) begin
      if (anyRst) begin
         store_reg <= 7'h00;
         value_reg <= 12'h000;
      end else begin
         store_reg <= 7'h00;
         if (procResult.valid && accept && procResult.chan < 3'(CHAN_COUNT)) begin
            store_reg[procResult.chan] <= 1'b1;
            value_reg <= procResult.value;
         end
      end
   end

   // data-available flags, a new store wins over a read clear
   generate
      for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_dav
         always_ff @(posedge clock) begin
            if (anyRst) begin
               dav_reg[c] <= 1'b0;
            end else if (store_reg[c]) begin
               dav_reg[c] <= 1'b1;
            end else if (allRegsRead[c]) begin
               dav_reg[c] <= 1'b0;
            end
         end
         assign davShown[c] = dav_reg[c] & ~filterBusy[c];
      end
   endgenerate

   assign davAny = |davShown;

   // combined interrupt pin select
   always_ff @(posedge clock) begin
      if (anyRst) begin
         pin_reg <= 1'b1;
      end else if (config_reg[CFG_SEL_LO]) begin
         pin_reg <= ~davAny;
      end else if (config_reg[CFG_SEL_HI]) begin
         pin_reg <= penSync2_reg;
      end else begin
         pin_reg <= penSync2_reg & ~davAny;
      end
   end

   // reset flag: zero after any reset until software polls the status
   always_ff @(posedge clock) begin
      if (anyRst) begin
         resetFlag_reg <= STATUS_RESET[STS_RST_FLAG];
      end else if (rdStatus) begin
         resetFlag_reg <= 1'b1;
      end
   end

   // power-down status follows its input only while the converter is awake
   always_ff @(posedge clock) begin
      if (anyRst) begin
         powerdown_state_reg <= STATUS_RESET[STS_PDN];
      end else if (running || !penSync2_reg) begin
         powerdown_state_reg <= powerdownIn;
      end
   end

   // read words
   assign funcWord = {driverBits_reg, funcOneHot_reg};
   always_comb begin
      statusWord = 16'h0000;
      statusWord[15:STS_DAV_LSB] = {davShown[0], davShown[1], davShown[2], davShown[3],
                                    davShown[4], davShown[5], davShown[6]};
      statusWord[STS_RST_FLAG] = resetFlag_reg;
      statusWord[STS_XOK] = xPanelOk;
      statusWord[STS_YOK] = yPanelOk;
      statusWord[STS_YNS] = yNoShort;
      statusWord[STS_PDN] = powerdown_state_reg;
      statusWord[1:0] = VERSION_ID;
   end

   // read data captured in the setup cycle
   always_ff @(posedge clock) begin
      if (anyRst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         unique case (paddr)
            ADDR_CONFIG: rdata_reg <= {16'h0000, config_reg};
            ADDR_FUNC: rdata_reg <= {16'h0000, funcWord};
            ADDR_STATUS: rdata_reg <= {16'h0000, statusWord};
            ADDR_CONTROL: rdata_reg <= {24'h000000, control_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // outputs to the conversion sequencer
   assign combinedIrqPin = pin_reg;
   assign storeStrobe = store_reg;
   assign storeValue = value_reg;
   assign funcStart = start_reg;
   assign funcCode = control_reg[3:0];
   assign selfScanSel = control_reg[CTL_SELF_SCAN];
   assign stopReq = stop_reg;
   assign convBusy = running | (|filterBusy);
   assign softResetOut = softRst_reg;
endmodule : tspc_regs
`default_nettype wire

/* File: test/tspc_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tspc_conv_model
   import tspc_pkg::*;
(
   input wire logic clock,
   input wire logic go,
   input wire logic [2:0] goChan,
   input wire logic [11:0] goVal,
   input wire logic readAll,
   output tspc_pkg::tspc_result_t procResult,
   output logic [6:0] allRegsRead
);
   tspc_result_t res = '0;
   logic [6:0] rdAll = 7'h0;
   assign procResult = res;
   assign allRegsRead = rdAll;
   // one-cycle result; idle fields invert so stale data never matches
   always @(posedge clock) begin
      res.valid <= go;
      res.chan <= go ? goChan : ~res.chan;
      res.value <= go ? goVal : ~res.value;
   end
   // host has read out every updated register
   always @(posedge clock) begin
      rdAll <= {7{readAll}};
   end
endmodule : tspc_conv_model
`default_nettype wire

/* File: test/tspc_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tspc_regs_props
   import tspc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic penTouchIrq_n,
   input wire logic combinedIrqPin,
   input wire tspc_pkg::tspc_result_t procResult,
   input wire tspc_pkg::tspc_thresh_t thresholds,
   input wire logic [6:0] filterBusy,
   input wire logic [6:0] chanFilterOn,
   input wire logic [3:0] filterSetting,
   input wire logic [6:0] storeStrobe,
   input wire logic [11:0] storeValue,
   input wire logic funcStart,
   input wire logic [3:0] funcCode,
   input wire logic stopReq,
   input wire logic convBusy,
   input wire logic softResetOut
);
   logic [15:0] cfg;
   logic cfgWr;
   logic ctlWr;
   // bus write strobes
   assign cfgWr = psel && penable && pwrite && paddr == ADDR_CONFIG;
   assign ctlWr = psel && penable && pwrite && paddr == ADDR_CONTROL;
   // shadow of the config register
   always_ff @(posedge clock) begin
      if (sys_rst || softResetOut) begin
         cfg <= CONFIG_RESET;
      end else if (cfgWr) begin
         cfg <= pwdata[15:0] & CONFIG_WMASK;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst || softResetOut);
   a_filter_map: assert property (
      chanFilterOn == ({7{|cfg[13:10]}} &
                       {cfg[0], cfg[0], cfg[1], cfg[2], cfg[2], cfg[3], cfg[4]}))
      else $error("channel filter enables wrong");
   a_filter_rdback: assert property (filterSetting == cfg[13:10])
      else $error("filter setting differs from config");
   a_zone_off: assert property (
      procResult.valid && procResult.chan == CHAN_AUX && cfg[7:6] == ZONE_OFF
      |=> storeStrobe[4] && storeValue == $past(procResult.value))
      else $error("zone off result not stored");
   a_zone_drop: assert property (
      procResult.valid && procResult.chan == CHAN_AUX && cfg[7:6] == ZONE_BELOW
      && procResult.value >= thresholds.auxLow |=> !storeStrobe[4])
      else $error("zone miss stored");
   a_temp_above: assert property (
      procResult.valid && procResult.chan == CHAN_TEMP1 && cfg[9:8] == 2'h3
      && procResult.value > thresholds.tempHigh |=> storeStrobe[5])
      else $error("temp above zone not stored");
   a_pin_pen: assert property (
      (cfg[15:14] == 2'h2 && $stable(penTouchIrq_n))[*4]
      |=> combinedIrqPin == $past(penTouchIrq_n))
      else $error("pin does not follow pen");
   a_pin_dav: assert property (
      cfg[14] && storeStrobe != 7'h0 ##1 cfg[14] && filterBusy == 7'h0
      |=> !combinedIrqPin)
      else $error("pin not low with data");
   a_func_start: assert property (
      ctlWr && pwdata[7] && pwdata[3:0] < 4'hd
      |=> funcStart && funcCode == $past(pwdata[3:0]))
      else $error("function start missing");
   a_stop_pulse: assert property (ctlWr && pwdata[5] |=> stopReq ##1 !stopReq)
      else $error("stop pulse wrong");
   a_busy_lvl: assert property (filterBusy != 7'h0 |-> convBusy)
      else $error("busy not shown");
   // main scenarios reached
   cover property (cfgWr ##1 cfg[15:14] == 2'h2);
   cover property (storeStrobe[5]);
   cover property (funcStart);
endmodule : tspc_regs_props
bind tspc_regs tspc_regs_props i_tspc_regs_props (.clock, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .penTouchIrq_n, .combinedIrqPin, .procResult, .thresholds,
   .filterBusy, .chanFilterOn, .filterSetting, .storeStrobe, .storeValue, .funcStart,
   .funcCode, .stopReq, .convBusy, .softResetOut);
`default_nettype wire

/* File: test/tspc_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tspc_regs_tb_top;
   import tspc_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, combinedIrqPin, pinExp, errv, selScan;
   logic penTouchIrq_n = 1'b1, funcDone = 1'b0, scanNoTouch = 1'b0, go = 1'b0, readAll = 1'b0;
   logic [6:0] filterBusy = 7'h0, allRegsRead;
   logic [2:0] goChan = 3'h0;
   logic [11:0] goVal = 12'h0, v;
   tspc_drivers_t drivers = 4'h0;
   tspc_drivers_t drvT [3] = '{4'hc, 4'h3, 4'h6};
   tspc_result_t procResult;
   int n_fail = 0, tests_run = 0;
   tspc_regs i_tspc_regs (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .penTouchIrq_n, .combinedIrqPin, .procResult,
      .thresholds({12'h0c8, 12'h064, 12'h0c8, 12'h064}), .drivers, .filterBusy,
      .allRegsRead, .funcDone, .scanNoTouch, .xPanelOk(1'b0), .yPanelOk(1'b0),
      .yNoShort(1'b0), .powerdownIn(1'b1), .chanFilterOn(), .filterSetting(),
      .storeStrobe(), .storeValue(), .funcStart(), .funcCode(), .selfScanSel(selScan),
      .stopReq(), .convBusy(), .softResetOut());
   tspc_conv_model i_tspc_conv_model (.clock, .go, .goChan, .goVal, .readAll,
      .procResult, .allRegsRead);
   // 25 MHz clock
   initial begin
      forever #20 clock = ~clock;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rdv, exp);
   endtask : rd
   task automatic send(input logic [2:0] ch, input logic [11:0] val);
      go <= 1'b1;
      goChan <= ch;
      goVal <= val;
      @(posedge clock);
      go <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : send
   task automatic clr();
      readAll <= 1'b1;
      @(posedge clock);
      readAll <= 1'b0;
      @(posedge clock);
   endtask : clr
   task automatic fdone();
      funcDone <= 1'b1;
      @(posedge clock);
      funcDone <= 1'b0;
      @(posedge clock);
   endtask : fdone
   function automatic logic zok(input int z, input int k);
      return z == 0 || z == k + 1;
   endfunction : zok
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
   // test sequence
   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd("config", ADDR_CONFIG, 32'h0);
      rd("func", ADDR_FUNC, 32'h0);
      rd("status", ADDR_STATUS, 32'h6);
      rd("status", ADDR_STATUS, 32'h86);
      apb(1'b1, ADDR_CONFIG, 32'h001f);
      rd("bypass", ADDR_CONFIG, 32'h1f);
      apb(1'b1, ADDR_CONFIG, 32'hffffffff);
      rd("config", ADDR_CONFIG, 32'hffdf);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", {31'h0, errv}, 32'h1);
      chk("unmapped data", rdv, 32'h0);
      $display("done registers");
      // zone codes on aux and temp at once, values below, between and above
      for (int z = 0; z < 4; z++) begin
         for (int k = 0; k < 3; k++) begin
            v = 12'(12'h032 + 12'h064 * k);
            apb(1'b1, ADDR_CONFIG, {22'h0, 2'(3 - z), 2'(z), 6'h0});
            send(CHAN_AUX, v);
            send(CHAN_TEMP1, v);
            rd("zone", ADDR_STATUS, {20'h0, zok(z, k), zok(3 - z, k), 10'h086});
            clr();
            rd("zone", ADDR_STATUS, 32'h86);
         end
      end
      apb(1'b1, ADDR_CONFIG, 32'h0);
      filterBusy <= 7'h10;
      send(CHAN_AUX, 12'h032);
      rd("busy", ADDR_STATUS, 32'h86);
      filterBusy <= 7'h0;
      rd("held", ADDR_STATUS, 32'h886);
      clr();
      rd("read out", ADDR_STATUS, 32'h86);
      $display("done zones");
      // pin select modes against pen and data
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, ADDR_CONFIG, {16'h0, 2'(i >> 2), 14'h0});
         penTouchIrq_n <= i[1];
         if (i[0]) send(3'h0, 12'h123);
         repeat (6) @(posedge clock);
         pinExp = i[2] ? !i[0] : (i[3] ? i[1] : i[1] && !i[0]);
         chk("pin", {31'h0, combinedIrqPin}, {31'h0, pinExp});
         clr();
      end
      penTouchIrq_n <= 1'b1;
      $display("done pin");
      // functions with driver pairs, ended by completion or stop
      for (int j = 0; j < 3; j++) begin
         drivers <= drvT[j];
         apb(1'b1, ADDR_CONTROL, 32'(8'h82 + 5 * j));
         @(posedge clock); // driver bits follow the running bit by a cycle
         rd("func", ADDR_FUNC, 32'((16'h2000 << j) | (16'h1 << (2 + 5 * j))));
         if (j == 1) apb(1'b1, ADDR_CONTROL, 32'h20);
         else fdone();
         rd("func end", ADDR_FUNC, 32'h0);
      end
      drivers <= 4'h0;
      apb(1'b1, ADDR_CONTROL, 32'h90);
      chk("scan select", {31'h0, selScan}, 32'h1);
      scanNoTouch <= 1'b1;
      fdone();
      rd("self scan", ADDR_FUNC, 32'h1);
      scanNoTouch <= 1'b0;
      $display("done functions");
      // software reset clears all and drops the flag
      apb(1'b1, ADDR_CONFIG, 32'h1234);
      apb(1'b1, ADDR_CONTROL, 32'h40);
      apb(1'b1, ADDR_CONTROL, 32'h0);
      rd("config", ADDR_CONFIG, 32'h0);
      rd("func", ADDR_FUNC, 32'h0);
      rd("status", ADDR_STATUS, 32'h6);
      $display("done soft reset");
      end_of_test();
   end
endmodule : tspc_regs_tb_top
`default_nettype wire
